// File: sso_pkg.sv
// Constants shared by the servo status-output block.
// Assumes a 50 MHz control clock and a 32-bit APB register port.
package sso_pkg;
	// Clock rate and power-on settling window
	localparam int CLK_HZ = 50000000;
	localparam int CLK_KHZ = CLK_HZ / 1000;
	localparam int POR_MIN_MS = 2500;
	localparam int POR_MAX_MS = 3500;
	// Whole cycles; the products are exact at this rate, so no rounding is lost
	localparam int POR_MIN_CYC = POR_MIN_MS * CLK_KHZ;
	localparam int POR_MAX_CYC = POR_MAX_MS * CLK_KHZ;
	localparam int POR_DEF_CYC = (POR_MIN_CYC + POR_MAX_CYC) / 2;
	localparam int POR_CNT_W = 28;

	// Zero-speed detection
	localparam logic [15:0] ZSP_LEVEL_RST = 16'h0032;
	localparam logic [16:0] ZSP_HYST = 17'h00014;

	// Warning codes that count as battery warnings
	localparam logic [11:0] WARN_BATT_CABLE = 12'h092;
	localparam logic [11:0] WARN_BATT = 12'h09F;

	// Control modes reported by the core
	localparam logic [1:0] MODE_POS = 2'h0;
	localparam logic [1:0] MODE_VEL = 2'h1;
	localparam logic [1:0] MODE_TRQ = 2'h2;

	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ZSPD = 8'h04;
	localparam logic [7:0] OFS_GPO = 8'h08;
	localparam logic [7:0] OFS_PINS = 8'h0C;
	localparam logic [7:0] OFS_ISTAT = 8'h10;
	localparam logic [7:0] OFS_IMASK = 8'h14;

	// Field positions and widths
	localparam int CTRL_RT_EN = 0;
	localparam int GPO_W = 3;
	localparam int PINS_W = 15;
	localparam int INT_W = 6;
	localparam int INT_WARN = 0;
	localparam int INT_BATT = 1;
	localparam int INT_STOP = 2;
	localparam int INT_ABS = 3;
	localparam int INT_RT = 4;
	localparam int INT_ZSP = 5;

	// Values after reset
	localparam logic CTRL_RT_RST = 1'b0;
	localparam logic [2:0] GPO_RST = 3'h0;
	localparam logic [5:0] IMASK_RST = 6'h00;
endpackage : sso_pkg

// File: sso_por_timer.sv
// Power-on settling timer for the status outputs.
// Assumes reset is released once the control clock runs.
`timescale 1ns/1ns
module sso_por_timer #(
	parameter int unsigned CYCLES = sso_pkg::POR_DEF_CYC
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Window elapsed, level
	output logic done
);
	typedef struct packed {
		logic [sso_pkg::POR_CNT_W-1:0] cnt;
		logic done;
	} sso_tmr_s;

	sso_tmr_s st_r;
	sso_tmr_s st_nxt;

	// Count once after reset, then hold done high for good
	always_comb
	begin
		st_nxt = st_r;
		if (!st_r.done)
		begin
			if (st_r.cnt == sso_pkg::POR_CNT_W'(CYCLES - 1))
				st_nxt.done = 1'b1;
			else
				st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign done = st_r.done;

	timer_exact_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(done) |-> $past(st_r.cnt) == sso_pkg::POR_CNT_W'(CYCLES - 1))
		else $error("settling window ended at the wrong count");
	timer_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		done |=> done)
		else $error("settling window restarted without reset");
endmodule : sso_por_timer

// File: sso_zero_speed.sv
// Zero-speed detector with a fixed hysteresis above the on-level.
// Assumes speed magnitude comes from logic on the same clock.
`timescale 1ns/1ns
module sso_zero_speed (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Speed magnitude and on-level, same units
	input wire logic [15:0] speed_mag,
	input wire logic [15:0] level,
	// Zero speed flag, registered
	output logic zero_speed
);
	typedef struct packed {
		logic zs;
	} sso_zsp_s;

	sso_zsp_s st_r;
	sso_zsp_s st_nxt;
	logic [16:0] off_level;

	// Off-level is wider than the speed so a level near full scale cannot wrap
	assign off_level = {1'b0, level} + sso_pkg::ZSP_HYST;

	// Enter at or below the level, leave only at level plus hysteresis
	always_comb
	begin
		st_nxt = st_r;
		if (!st_r.zs && speed_mag <= level)
			st_nxt.zs = 1'b1;
		else if (st_r.zs && {1'b0, speed_mag} >= off_level)
			st_nxt.zs = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign zero_speed = st_r.zs;

	zsp_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
		speed_mag <= level |=> zero_speed)
		else $error("zero speed not flagged at or below level");
	zsp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		zero_speed && {1'b0, speed_mag} < off_level |=> zero_speed)
		else $error("zero speed dropped inside hysteresis band");
	zsp_leave_a: assert property (@(posedge pclk) disable iff (!presetn)
		{1'b0, speed_mag} >= off_level |=> !zero_speed)
		else $error("zero speed kept above off-level");
endmodule : sso_zero_speed

// File: sso_status_out.sv
// Servo amplifier status outputs with an APB register port.
// Assumes core status inputs are on pclk; outputs feed pin drivers.
`timescale 1ns/1ns
module sso_status_out #(
	parameter int unsigned POR_CYCLES = sso_pkg::POR_DEF_CYC
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core status
	input wire logic warning_active,
	input wire logic [11:0] warning_code,
	input wire logic motor_stop_warning,
	input wire logic alarm_active,
	input wire logic servo_on,
	input wire logic [1:0] ctrl_mode,
	input wire logic gain1_req,
	input wire logic gain2_req,
	input wire logic abs_undetermined,
	input wire logic ride_through_event,
	input wire logic full_loop_on,
	input wire logic [15:0] motor_speed,
	input wire logic [15:0] speed_limit,
	input wire logic [15:0] motor_torque,
	input wire logic [15:0] torque_limit,
	// Status outputs
	output logic warning_out,
	output logic battery_alert_out,
	output logic motor_stop_alert_out,
	output logic gain_set1_active,
	output logic gain_set2_active,
	output logic abs_position_lost,
	output logic ride_through_active,
	output logic full_loop_active,
	output logic brake_interlock,
	output logic speed_limiting,
	output logic zero_speed_detect,
	output logic torque_limiting,
	output logic general_out_a,
	output logic general_out_b,
	output logic general_out_c,
	// Interrupt, level
	output logic irq
);
	// All state in one struct; the pin register doubles as the readback word
	typedef struct packed {
		logic ride_through_enable_setting;
		logic [15:0] zero_speed_level_setting;
		logic [2:0] gpo;
		logic [5:0] istat;
		logic [5:0] imask;
		logic [5:0] ev_prev;
		logic [14:0] pins;
		logic [31:0] rdata;
		logic rerr;
	} sso_main_s;

	sso_main_s st_r;
	sso_main_s st_nxt;
	logic por_done;
	logic zsp_raw;
	logic [15:0] spd_mag;
	logic [15:0] trq_mag;
	logic batt_cond;
	logic torque_mode;
	logic setup_ph;
	logic wr_acc;
	logic [5:0] ev_now;
	logic [5:0] ev_rise;
	logic [14:0] pins_nxt;
	logic [31:0] rd_mux;
	logic rd_err;

	// Settling window after power-on
	// Simulation shortens it through the parameter; hardware keeps the default
	sso_por_timer #(
		.CYCLES(POR_CYCLES)
	) u_por (
		.pclk(pclk),
		.presetn(presetn),
		.done(por_done)
	);

	// Zero speed with hysteresis on the configured level
	// The detector runs through the window; only the pin is gated
	sso_zero_speed u_zsp (
		.pclk(pclk),
		.presetn(presetn),
		.speed_mag(spd_mag),
		.level(st_r.zero_speed_level_setting),
		.zero_speed(zsp_raw)
	);

	// Magnitudes; full-scale negative maps to 0x8000, still correct as unsigned
	// Core inputs share pclk, so they are read without synchronisers
	assign spd_mag = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
	assign trq_mag = motor_torque[15] ? 16'(-motor_torque) : motor_torque;
	assign torque_mode = (ctrl_mode == sso_pkg::MODE_TRQ);
	assign batt_cond = warning_active && (warning_code == sso_pkg::WARN_BATT_CABLE
		|| warning_code == sso_pkg::WARN_BATT);

	// APB phases; zero wait states, so the access phase is always the last
	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign pready = penable;

	// Pin values, bit order matches the readback register
	always_comb
	begin
		pins_nxt = '0;
		// Warnings read as on until the window proves none is present
		pins_nxt[0] = !por_done || warning_active;
		pins_nxt[1] = !por_done || batt_cond;
		pins_nxt[2] = !por_done || motor_stop_warning;
		if (por_done)
		begin
			// Gain set 2 takes priority when both are requested
			pins_nxt[3] = gain1_req && !gain2_req;
			pins_nxt[4] = gain2_req;
			pins_nxt[5] = abs_undetermined;
			// Ride-through is reported only once software has enabled it
			pins_nxt[6] = ride_through_event && st_r.ride_through_enable_setting;
			pins_nxt[7] = full_loop_on;
			// No brake delay here; the controller must wait for standstill itself
			pins_nxt[8] = servo_on && !alarm_active;
			// Limits compare magnitudes, so either direction of travel counts
			pins_nxt[9] = servo_on && torque_mode && spd_mag >= speed_limit;
			pins_nxt[10] = zsp_raw;
			pins_nxt[11] = servo_on && !torque_mode && trq_mag >= torque_limit;
			pins_nxt[14:12] = st_r.gpo;
		end
	end

	// Events that raise sticky interrupt bits on their rising edge
	assign ev_now = {zsp_raw, pins_nxt[6], abs_undetermined, motor_stop_warning,
		batt_cond, warning_active};
	assign ev_rise = ev_now & ~st_r.ev_prev;

	// Read mux, sampled in the setup phase so prdata leaves a flip-flop
	// Unmapped words read zero and raise the slave error in the access phase
	always_comb
	begin
		rd_mux = '0;
		rd_err = 1'b0;
		unique case (paddr)
			sso_pkg::OFS_CTRL: rd_mux[sso_pkg::CTRL_RT_EN] = st_r.ride_through_enable_setting;
			sso_pkg::OFS_ZSPD: rd_mux[15:0] = st_r.zero_speed_level_setting;
			sso_pkg::OFS_GPO: rd_mux[2:0] = st_r.gpo;
			sso_pkg::OFS_PINS: rd_mux[14:0] = st_r.pins;
			sso_pkg::OFS_ISTAT: rd_mux[5:0] = st_r.istat;
			sso_pkg::OFS_IMASK: rd_mux[5:0] = st_r.imask;
			default: rd_err = 1'b1;
		endcase
	end

	// Next state: register writes, sticky status, pin update
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pins = pins_nxt;
		st_nxt.ev_prev = ev_now;
		if (setup_ph)
		begin
			st_nxt.rdata = pwrite ? 32'h00000000 : rd_mux;
			st_nxt.rerr = rd_err;
		end
		if (wr_acc)
		begin
			unique case (paddr)
				sso_pkg::OFS_CTRL: st_nxt.ride_through_enable_setting = pwdata[sso_pkg::CTRL_RT_EN];
				sso_pkg::OFS_ZSPD: st_nxt.zero_speed_level_setting = pwdata[15:0];
				sso_pkg::OFS_GPO: st_nxt.gpo = pwdata[2:0];
				sso_pkg::OFS_ISTAT: st_nxt.istat = st_r.istat & ~pwdata[5:0];
				sso_pkg::OFS_IMASK: st_nxt.imask = pwdata[5:0];
				// Read-only and unmapped words ignore writes
				default: st_nxt.istat = st_r.istat;
			endcase
		end
		// A new event beats a clear in the same cycle
		st_nxt.istat = st_nxt.istat | ev_rise;
	end

	// Settings return to their defaults; pins and status clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.ride_through_enable_setting <= sso_pkg::CTRL_RT_RST;
			st_r.zero_speed_level_setting <= sso_pkg::ZSP_LEVEL_RST;
			st_r.gpo <= sso_pkg::GPO_RST;
			st_r.imask <= sso_pkg::IMASK_RST;
		end
		else
			st_r <= st_nxt;
	end

	// Output wiring from the pin register
	// Every pin leaves a flip-flop, so the controller never sees a decode glitch
	assign warning_out = st_r.pins[0];
	assign battery_alert_out = st_r.pins[1];
	assign motor_stop_alert_out = st_r.pins[2];
	assign gain_set1_active = st_r.pins[3];
	assign gain_set2_active = st_r.pins[4];
	assign abs_position_lost = st_r.pins[5];
	assign ride_through_active = st_r.pins[6];
	assign full_loop_active = st_r.pins[7];
	assign brake_interlock = st_r.pins[8];
	assign speed_limiting = st_r.pins[9];
	assign zero_speed_detect = st_r.pins[10];
	assign torque_limiting = st_r.pins[11];
	assign general_out_a = st_r.pins[12];
	assign general_out_b = st_r.pins[13];
	assign general_out_c = st_r.pins[14];
	assign irq = |(st_r.istat & st_r.imask);
	assign prdata = st_r.rdata;
	assign pslverr = penable && st_r.rerr;

	// Checks, all on pclk and quiet during reset
	// Pin behaviour first, then the interrupt status, the register port and the remaining pin checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	warn_follow_a: assert property (warning_active |=> warning_out)
		else $error("warning output missed an active warning");
	warn_clear_a: assert property (por_done && !warning_active |=> !warning_out)
		else $error("warning output on with no warning after window");
	batt_set_a: assert property (batt_cond |=> battery_alert_out)
		else $error("battery alert missed a battery code");
	batt_clear_a: assert property (por_done && !batt_cond |=> !battery_alert_out)
		else $error("battery alert on without battery warning");
	stop_follow_a: assert property (por_done |=> motor_stop_alert_out == $past(motor_stop_warning))
		else $error("motor stop alert does not follow its warning");
	gain_one_a: assert property (por_done |=> gain_set1_active == $past(gain1_req && !gain2_req))
		else $error("gain set 1 output wrong");
	gain_two_a: assert property (por_done |=> gain_set2_active == $past(gain2_req))
		else $error("gain set 2 output wrong");
	abs_lost_a: assert property (por_done && abs_undetermined |=> abs_position_lost)
		else $error("absolute position lost not flagged");
	ride_gate_a: assert property (ride_through_active |-> $past(st_r.ride_through_enable_setting))
		else $error("ride-through flagged while disabled");
	full_loop_a: assert property (por_done |=> full_loop_active == $past(full_loop_on))
		else $error("full loop output wrong");
	brake_off_a: assert property (!servo_on || alarm_active |=> !brake_interlock)
		else $error("brake interlock on at servo-off or alarm");
	speed_lim_a: assert property (speed_limiting |-> $past(servo_on && torque_mode))
		else $error("speed limiting outside torque mode or servo-on");
	torque_lim_a: assert property (torque_limiting |-> $past(servo_on && !torque_mode))
		else $error("torque limiting in torque mode or at servo-off");
	gpo_write_a: assert property (por_done && wr_acc && paddr == sso_pkg::OFS_GPO
		|=> ##1 {general_out_c, general_out_b, general_out_a} == $past(pwdata[2:0], 2))
		else $error("general outputs did not follow the write");
	window_off_a: assert property (!por_done |=> !brake_interlock && !general_out_a && !zero_speed_detect)
		else $error("output active inside settling window");
	sticky_set_a: assert property (ev_rise[sso_pkg::INT_WARN] |=> st_r.istat[sso_pkg::INT_WARN])
		else $error("warning event lost from interrupt status");
	// Every event source lands in its own status bit
	sticky_batt_a: assert property (ev_rise[sso_pkg::INT_BATT] |=> st_r.istat[sso_pkg::INT_BATT])
		else $error("battery event lost from interrupt status");
	sticky_stop_a: assert property (ev_rise[sso_pkg::INT_STOP] |=> st_r.istat[sso_pkg::INT_STOP])
		else $error("motor stop event lost from interrupt status");
	sticky_abs_a: assert property (ev_rise[sso_pkg::INT_ABS] |=> st_r.istat[sso_pkg::INT_ABS])
		else $error("position lost event lost from interrupt status");
	sticky_ride_a: assert property (ev_rise[sso_pkg::INT_RT] |=> st_r.istat[sso_pkg::INT_RT])
		else $error("ride-through event lost from interrupt status");
	sticky_zero_a: assert property (ev_rise[sso_pkg::INT_ZSP] |=> st_r.istat[sso_pkg::INT_ZSP])
		else $error("zero speed event lost from interrupt status");

	// Status bits leave only through a write of one, and a new event beats that write
	status_keep_a: assert property (!(wr_acc && paddr == sso_pkg::OFS_ISTAT)
		|=> (st_r.istat & $past(st_r.istat)) == $past(st_r.istat))
		else $error("interrupt status bit dropped without a clear");
	w1c_clear_a: assert property (wr_acc && paddr == sso_pkg::OFS_ISTAT
		|=> (st_r.istat & $past(pwdata[5:0] & ~ev_rise)) == 6'h00)
		else $error("interrupt status bit survived its clear");

	// Register port: read data from the setup phase, error on unmapped words, writes land
	read_data_a: assert property (psel && !penable && !pwrite |=> prdata == $past(rd_mux))
		else $error("read data differs from the addressed register");
	slave_err_a: assert property (psel && !penable ##1 psel && penable |-> pslverr == $past(rd_err))
		else $error("slave error does not match the address decode");
	ctrl_write_a: assert property (wr_acc && paddr == sso_pkg::OFS_CTRL
		|=> st_r.ride_through_enable_setting == $past(pwdata[sso_pkg::CTRL_RT_EN]))
		else $error("ride-through enable write lost");
	level_write_a: assert property (wr_acc && paddr == sso_pkg::OFS_ZSPD
		|=> st_r.zero_speed_level_setting == $past(pwdata[15:0]))
		else $error("zero speed level write lost");
	mask_write_a: assert property (wr_acc && paddr == sso_pkg::OFS_IMASK
		|=> st_r.imask == $past(pwdata[5:0]))
		else $error("interrupt mask write lost");

	// Outputs that must come on once the window is over, and the warnings inside it
	zsp_pin_a: assert property (por_done |=> zero_speed_detect == $past(zsp_raw))
		else $error("zero speed output does not follow its detector");
	brake_on_a: assert property (por_done && servo_on && !alarm_active |=> brake_interlock)
		else $error("brake interlock stayed off while running");
	ride_pass_a: assert property (por_done && ride_through_event
		&& st_r.ride_through_enable_setting |=> ride_through_active)
		else $error("ride-through not flagged while enabled");
	speed_set_a: assert property (por_done && servo_on && torque_mode
		&& spd_mag >= speed_limit |=> speed_limiting)
		else $error("speed limiting missed in torque mode");
	torque_set_a: assert property (por_done && servo_on && !torque_mode
		&& trq_mag >= torque_limit |=> torque_limiting)
		else $error("torque limiting missed at the limit");
	window_warn_a: assert property (!por_done |=> warning_out && battery_alert_out
		&& motor_stop_alert_out)
		else $error("warning outputs off inside settling window");

	// Main scenarios the bench should reach
	brake_rel_c: cover property (por_done && servo_on && !alarm_active ##1 brake_interlock);
	zsp_cycle_c: cover property (zero_speed_detect ##[1:50] !zero_speed_detect);
	gpo_set_c: cover property (general_out_a && general_out_b && general_out_c);
	irq_c: cover property ($rose(irq));
	err_c: cover property (psel && penable && pslverr);
endmodule : sso_status_out

// File: sso_ctrl_model.sv
// Model of the machine controller that reads the status pins.
// Assumes the pins arrive registered on pclk.
`timescale 1ns/1ns
module sso_ctrl_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Run request and pin read back
	input wire logic run_cmd,
	input wire logic zero_speed_detect,
	// Servo-on command to the amplifier
	output logic servo_on
);
	// Servo-off waits for zero speed detect; an alarm still drops brake_interlock at once, whatever the speed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			servo_on <= 1'b0;
		else if (run_cmd)
			servo_on <= 1'b1;
		else if (zero_speed_detect)
			servo_on <= 1'b0;
	end
endmodule : sso_ctrl_model

// File: tb_top.sv
// Self-checking bench for the status-output block.
// Assumes the controller model owns servo_on; the bench drives the rest.
`timescale 1ns/1ns
module tb_top;
	localparam int POR = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run_cmd = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, irq, servo_on;
	logic warn = 1'b0, stopw = 1'b0, alarm = 1'b0, g1 = 1'b1, g2 = 1'b0, absu = 1'b1, rte = 1'b0, fl = 1'b0;
	logic [11:0] wcode = 12'h000;
	logic [1:0] mode = 2'h0;
	logic [15:0] spd = 16'h0, slim = 16'h0, trq = 16'h0, tlim = 16'h0;
	wire logic [14:0] pins;
	int mismatches = 0, tests_run = 0;

	// Clock at 50 MHz
	always #10 pclk = ~pclk;

	sso_status_out #(.POR_CYCLES(POR)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .warning_active(warn), .warning_code(wcode),
		.motor_stop_warning(stopw), .alarm_active(alarm), .servo_on(servo_on), .ctrl_mode(mode),
		.gain1_req(g1), .gain2_req(g2), .abs_undetermined(absu), .ride_through_event(rte),
		.full_loop_on(fl), .motor_speed(spd), .speed_limit(slim), .motor_torque(trq),
		.torque_limit(tlim), .warning_out(pins[0]), .battery_alert_out(pins[1]),
		.motor_stop_alert_out(pins[2]), .gain_set1_active(pins[3]), .gain_set2_active(pins[4]),
		.abs_position_lost(pins[5]), .ride_through_active(pins[6]), .full_loop_active(pins[7]),
		.brake_interlock(pins[8]), .speed_limiting(pins[9]), .zero_speed_detect(pins[10]),
		.torque_limiting(pins[11]), .general_out_a(pins[12]), .general_out_b(pins[13]),
		.general_out_c(pins[14]), .irq(irq));

	sso_ctrl_model i_ctrl (.pclk(pclk), .presetn(presetn), .run_cmd(run_cmd),
		.zero_speed_detect(pins[10]), .servo_on(servo_on));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Wait edges, then let their updates land
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait budget here; only the watchdog ends a stuck transfer
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic xerr);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
		chk(e, xerr);
	endtask : rdc

	// Window: warnings shown, all else held off, then outputs follow inputs
	task automatic t_window;
		tick(1);
		chk(pins[2:0], 3'h7);
		chk(pins[14:3], 12'h000);
		rdc(sso_pkg::OFS_CTRL, 32'h0, 1'b0);
		rdc(sso_pkg::OFS_ZSPD, {16'h0, sso_pkg::ZSP_LEVEL_RST}, 1'b0);
		rdc(sso_pkg::OFS_GPO, 32'h0, 1'b0);
		rdc(sso_pkg::OFS_IMASK, 32'h0, 1'b0);
		rdc(8'h18, 32'h0, 1'b1);
		tick(POR);
		chk(pins[2:0], 3'h0);
		chk(pins[5:3], 3'h5);
	endtask : t_window

	// Warning codes, battery decode and drive-blocking warning
	task automatic t_warn;
		logic [11:0] cs [3] = '{sso_pkg::WARN_BATT_CABLE, sso_pkg::WARN_BATT, 12'h091};
		for (int i = 0; i < 3; i++)
		begin
			@(posedge pclk);
			warn <= 1'b1;
			wcode <= cs[i];
			tick(3);
			chk(pins[0], 1'b1);
			chk(pins[1], i < 2);
		end
		@(posedge pclk);
		warn <= 1'b0;
		stopw <= 1'b1;
		tick(3);
		chk(pins[2:1], 2'h2);
		@(posedge pclk);
		stopw <= 1'b0;
		tick(3);
		chk(pins[2:0], 3'h0);
	endtask : t_warn

	// Gain sets, position lost, full loop and gated ride-through
	task automatic t_levels;
		@(posedge pclk);
		g2 <= 1'b1;
		absu <= 1'b0;
		fl <= 1'b1;
		rte <= 1'b1;
		tick(3);
		chk(pins[7:3], 5'h12);
		wr(sso_pkg::OFS_CTRL, 32'h1);
		tick(3);
		chk(pins[6], 1'b1);
		@(posedge pclk);
		g1 <= 1'b0;
		g2 <= 1'b0;
		fl <= 1'b0;
		rte <= 1'b0;
		tick(3);
		chk(pins[7:3], 5'h00);
	endtask : t_levels

	// Brake, speed and torque limiting across modes and servo-off
	task automatic t_servo;
		@(posedge pclk);
		mode <= sso_pkg::MODE_TRQ;
		slim <= 16'h0064;
		spd <= 16'h0064;
		run_cmd <= 1'b1;
		tick(4);
		chk(pins[11:8], 4'h3);
		@(posedge pclk);
		spd <= 16'h0063;
		tick(3);
		chk(pins[9], 1'b0);
		@(posedge pclk);
		spd <= 16'h0064;
		mode <= sso_pkg::MODE_VEL;
		trq <= 16'hFF38;
		tlim <= 16'h00C8;
		tick(3);
		chk(pins[11:9], 3'h4);
		@(posedge pclk);
		alarm <= 1'b1;
		run_cmd <= 1'b0;
		tick(5);
		chk(pins[8], 1'b0);
		chk(servo_on, 1'b1);
		@(posedge pclk);
		alarm <= 1'b0;
		spd <= 16'h0;
		slim <= 16'h0;
		tlim <= 16'h0;
		mode <= sso_pkg::MODE_TRQ;
		tick(6);
		chk({servo_on, pins[11:8]}, 5'h04);
		@(posedge pclk);
		mode <= sso_pkg::MODE_POS;
		tick(3);
		chk(pins[11], 1'b0);
	endtask : t_servo

	// Zero speed with hysteresis, both directions, then a new level
	task automatic t_zero;
		logic [15:0] sp [11] = '{16'h0045, 16'h0046, 16'h0033, 16'h0032, 16'hFFBB, 16'hFFBA, 16'hFFCE,
			16'h000A, 16'h001D, 16'h001E, 16'h000B};
		logic [16:0] lv, mag;
		logic z;
		lv = {1'b0, sso_pkg::ZSP_LEVEL_RST};
		z = 1'b1;
		for (int i = 0; i < 11; i++)
		begin
			if (i == 7)
			begin
				wr(sso_pkg::OFS_ZSPD, 32'h0000000A);
				lv = 17'h0000A;
			end
			@(posedge pclk);
			spd <= sp[i];
			mag = sp[i][15] ? {1'b0, -sp[i]} : {1'b0, sp[i]};
			if (mag <= lv)
				z = 1'b1;
			else if (mag >= lv + sso_pkg::ZSP_HYST)
				z = 1'b0;
			tick(3);
			chk(pins[10], z);
		end
	endtask : t_zero

	// General outputs follow writes; pin register is read-only
	task automatic t_gpo;
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 8; i++)
		begin
			wr(sso_pkg::OFS_GPO, i);
			tick(2);
			chk(pins[14:12], i[2:0]);
		end
		wr(sso_pkg::OFS_PINS, 32'h0);
		apb(1'b0, sso_pkg::OFS_PINS, 32'h0, r, e);
		chk(r[14:12], 3'h7);
	endtask : t_gpo

	// Warning event: sticky status, mask and write-one clear
	task automatic t_irq;
		wr(sso_pkg::OFS_IMASK, 32'h1);
		wr(sso_pkg::OFS_ISTAT, 32'h3F);
		tick(1);
		chk(irq, 1'b0);
		@(posedge pclk);
		warn <= 1'b1;
		tick(3);
		chk(irq, 1'b1);
		rdc(sso_pkg::OFS_ISTAT, 32'h1, 1'b0);
		wr(sso_pkg::OFS_IMASK, 32'h0);
		tick(1);
		chk(irq, 1'b0);
		wr(sso_pkg::OFS_IMASK, 32'h1);
		wr(sso_pkg::OFS_ISTAT, 32'h1);
		tick(1);
		chk(irq, 1'b0);
	endtask : t_irq

	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// Main sequence after five reset cycles
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_window();
		t_warn();
		t_levels();
		t_servo();
		t_zero();
		t_gpo();
		t_irq();
		final_report();
	end

	// Watchdog far beyond the few hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		final_report();
	end
endmodule : tb_top
